// ==== rtl/csi_top.sv ====
// Card supply sequencer, supply control register and card interrupt gating
`include "csi_consts.svh"

module csi_top #(
    parameter int STEP_CYCLES = `CSI_STEP_CYCLES,
    parameter int TICK_CYCLES = `CSI_TICK_CYCLES
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [15:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [7:0] rd_data,
    input wire logic wait_timeout_evt,
    input wire logic rx_len_max_evt,
    input wire logic card_event_evt,
    input wire logic rx_avail_evt,
    input wire logic tx_event_evt,
    input wire logic tx_sent_evt,
    input wire logic tx_error_evt,
    input wire logic rx_error_evt,
    input wire logic supply_good_pin,
    input wire logic core_fault_pin,
    output logic irq,
    output logic companion_cmd_low_volt_n,
    output logic companion_cmd_high_volt_n,
    output logic [1:0] supply_level,
    output logic card_rst_n,
    output logic card_clk_en,
    output logic card_io_en,
    output logic circuit_power_down
);

    csi_pkg::csi_state_t state_q;
    csi_pkg::csi_state_t state_d;
    csi_pkg::csi_vsel_t lvl_q;

    logic [7:0] irq_en_q;
    logic [7:0] status_q;
    logic [7:0] timer_q;
    logic [1:0] sel_q;
    logic policy_q;
    logic rdy_q;
    logic pd_q;
    logic sync_mode_q;

    logic good_m_q;
    logic good_s_q;
    logic good_prev_q;
    logic fault_m_q;
    logic fault_s_q;
    logic fault_prev_q;

    logic emerg_q;
    logic auto_q;
    logic [15:0] step_q;

    logic wr_status;
    logic wr_irq_en;
    logic wr_ctrl;
    logic wr_timer;
    logic wr_mode;
    logic start_act;
    logic good_fall;
    logic fault_rise;
    logic emerg_now;
    logic powered;
    logic auto_deact;
    logic fw_deact;
    logic step_done;
    logic tmr_arm;
    logic tmr_expired;
    logic tmr_fail;
    logic [7:0] cause;

    // Address decode
    assign wr_status = wr_en && (addr == `CSI_ADDR_STATUS);
    assign wr_irq_en = wr_en && (addr == `CSI_ADDR_IRQ_EN);
    assign wr_ctrl = wr_en && (addr == `CSI_ADDR_CTRL);
    assign wr_timer = wr_en && (addr == `CSI_ADDR_TIMER);
    assign wr_mode = wr_en && (addr == `CSI_ADDR_MODE);

    // Pin synchronisers; the second stage and its delayed copy for edge detection are looked at
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            good_m_q <= 1'b0;
            good_s_q <= 1'b0;
            good_prev_q <= 1'b0;
            fault_m_q <= 1'b0;
            fault_s_q <= 1'b0;
            fault_prev_q <= 1'b0;
        end else begin
            good_m_q <= supply_good_pin;
            good_s_q <= good_m_q;
            good_prev_q <= good_s_q;
            fault_m_q <= core_fault_pin;
            fault_s_q <= fault_m_q;
            fault_prev_q <= fault_s_q;
        end
    end

    assign good_fall = good_prev_q && !good_s_q;
    assign fault_rise = fault_s_q && !fault_prev_q;

    // Interrupt enable register
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            irq_en_q <= `CSI_RST_IRQ_EN;
        end else if (wr_irq_en) begin
            irq_en_q <= wr_data;
        end
    end

    // Supply control register; the good bit is never stored from a write
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sel_q <= 2'h0;
            policy_q <= 1'b0;
            rdy_q <= 1'b0;
            pd_q <= 1'b0;
        end else if (wr_ctrl) begin
            // select taken whole from one write
            sel_q <= wr_data[`CSI_SEL_HI:`CSI_SEL_LO];
            policy_q <= wr_data[`CSI_POLICY_BIT];
            rdy_q <= wr_data[`CSI_RDY_BIT];
            pd_q <= wr_data[`CSI_PD_BIT];
        end
    end

    // Timer and mode registers
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            timer_q <= `CSI_RST_TIMER;
            sync_mode_q <= 1'b0;
        end else begin
            if (wr_timer) begin
                timer_q <= wr_data;
            end
            if (wr_mode) begin
                sync_mode_q <= wr_data[0];
            end
        end
    end

    // Supply stable timer, armed only while the supply ramps
    assign tmr_arm = (state_q == csi_pkg::CSI_RAMP);

    csi_timer #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_timer (
        .clk(clk),
        .rst_b(rst_b),
        .arm(tmr_arm),
        .limit(timer_q[3:0]),
        .expired(tmr_expired)
    );

    // expiry without supply good aborts activation
    assign tmr_fail = tmr_expired && !good_s_q;

    // emergency on core fault with policy clear
    assign emerg_now = fault_s_q && !policy_q;

    // Supply is on in these states, so deactivation has work to do
    assign powered = (state_q != csi_pkg::CSI_IDLE) && (state_q != csi_pkg::CSI_LOCK)
        && (state_q != csi_pkg::CSI_DEA_OFF);

    // card event, supply good loss, core fault emergency or timer failure
    assign auto_deact = powered && (card_event_evt || good_fall || emerg_now || tmr_fail);

    // Firmware-driven deactivation by writing a zero select
    assign fw_deact = wr_ctrl && (wr_data[`CSI_SEL_HI:`CSI_SEL_LO] == 2'h0);

    assign start_act = wr_ctrl && (wr_data[`CSI_SEL_HI:`CSI_SEL_LO] != 2'h0)
        && (state_q == csi_pkg::CSI_IDLE);

    // Contact step pacing
    assign step_done = (step_q == 16'(STEP_CYCLES - 1));

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            step_q <= 16'h0000;
        end else if (state_d != state_q || step_done) begin
            step_q <= 16'h0000;
        end else begin
            step_q <= step_q + 16'h0001;
        end
    end

    // Sequencer next state
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            csi_pkg::CSI_IDLE: begin
                if (start_act) begin
                    state_d = csi_pkg::CSI_RAMP;
                end
            end
            csi_pkg::CSI_RAMP: begin
                if (auto_deact || fw_deact) begin
                    state_d = csi_pkg::CSI_DEA_RST;
                // wait for good when ready-start set
                end else if (good_s_q && (rdy_q || timer_q[3:0] == 4'h0)) begin
                    state_d = csi_pkg::CSI_ACT_IO;
                end else if (tmr_expired) begin
                    state_d = csi_pkg::CSI_ACT_IO; // Good at expiry
                end
            end
            csi_pkg::CSI_ACT_IO: begin
                if (auto_deact || fw_deact) begin
                    state_d = csi_pkg::CSI_DEA_RST;
                end else if (step_done) begin
                    state_d = csi_pkg::CSI_ACT_CLK;
                end
            end
            csi_pkg::CSI_ACT_CLK: begin
                if (auto_deact || fw_deact) begin
                    state_d = csi_pkg::CSI_DEA_RST;
                end else if (step_done) begin
                    state_d = csi_pkg::CSI_ACTIVE;
                end
            end
            csi_pkg::CSI_ACTIVE: begin
                if (auto_deact || fw_deact) begin
                    state_d = csi_pkg::CSI_DEA_RST;
                end
            end
            // reset, clock, I/O before supply off
            csi_pkg::CSI_DEA_RST: begin
                if (step_done) begin
                    state_d = csi_pkg::CSI_DEA_CLK;
                end
            end
            csi_pkg::CSI_DEA_CLK: begin
                if (step_done) begin
                    state_d = csi_pkg::CSI_DEA_IO;
                end
            end
            csi_pkg::CSI_DEA_IO: begin
                if (step_done) begin
                    state_d = csi_pkg::CSI_DEA_OFF;
                end
            end
            csi_pkg::CSI_DEA_OFF: begin
                if (step_done) begin
                    state_d = auto_q ? csi_pkg::CSI_LOCK : csi_pkg::CSI_IDLE;
                end
            end
            csi_pkg::CSI_LOCK: begin
                // select must read zero before rearming
                if (sel_q == 2'h0) begin
                    state_d = csi_pkg::CSI_IDLE;
                end
            end
            default: begin
                state_d = csi_pkg::CSI_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= csi_pkg::CSI_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Remember whether this deactivation was automatic
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            auto_q <= 1'b0;
        end else if (start_act) begin
            auto_q <= 1'b0;
        end else if (auto_deact) begin
            auto_q <= 1'b1;
        end
    end

    // Target level latched at activation start
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            lvl_q <= csi_pkg::CSI_VCC_OFF;
        end else if (start_act) begin
            lvl_q <= csi_pkg::csi_vsel_t'(wr_data[`CSI_SEL_HI:`CSI_SEL_LO]);
        end else if (state_q == csi_pkg::CSI_DEA_OFF) begin
            lvl_q <= csi_pkg::CSI_VCC_OFF;
        end
    end

    // Emergency hold; kept until the sequencer is back at rest
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            emerg_q <= 1'b0;
        end else if (emerg_now) begin
            emerg_q <= 1'b1;
        end else if (state_q == csi_pkg::CSI_IDLE || state_q == csi_pkg::CSI_LOCK) begin
            emerg_q <= 1'b0;
        end
    end

    // Companion supply commands, active low
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            companion_cmd_low_volt_n <= 1'b1;
            companion_cmd_high_volt_n <= 1'b1;
        end else if (emerg_now || emerg_q) begin
            companion_cmd_low_volt_n <= 1'b1;
            companion_cmd_high_volt_n <= 1'b1;
        end else if (powered && state_d != csi_pkg::CSI_DEA_OFF) begin
            // 5V on the high line, others low line
            companion_cmd_low_volt_n <= !(lvl_q == csi_pkg::CSI_VCC_1V8 || lvl_q == csi_pkg::CSI_VCC_3V0);
            companion_cmd_high_volt_n <= !(lvl_q == csi_pkg::CSI_VCC_5V0);
        end else begin
            companion_cmd_low_volt_n <= 1'b1;
            companion_cmd_high_volt_n <= 1'b1;
        end
    end

    // Card contacts follow the sequencer
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            card_rst_n <= 1'b0;
            card_clk_en <= 1'b0;
            card_io_en <= 1'b0;
            supply_level <= 2'h0;
        end else begin
            card_rst_n <= (state_d == csi_pkg::CSI_ACTIVE);
            card_clk_en <= (state_d == csi_pkg::CSI_ACT_CLK) || (state_d == csi_pkg::CSI_ACTIVE)
                || (state_d == csi_pkg::CSI_DEA_RST && card_clk_en); // Clock outlives reset by one step
            card_io_en <= (state_d == csi_pkg::CSI_ACT_IO) || (state_d == csi_pkg::CSI_ACT_CLK)
                || (state_d == csi_pkg::CSI_ACTIVE)
                || ((state_d == csi_pkg::CSI_DEA_RST || state_d == csi_pkg::CSI_DEA_CLK) && card_io_en);
            supply_level <= (state_d == csi_pkg::CSI_DEA_OFF || !powered && state_d != csi_pkg::CSI_RAMP)
                ? 2'h0 : lvl_q;
        end
    end

    // Cause sources; bit 7 changes meaning in synchronous mode
    always_comb begin
        cause = {1'b0, 1'b0, 1'b0, rx_avail_evt, tx_event_evt, tx_sent_evt, tx_error_evt, rx_error_evt};
        cause[`CSI_CAUSE_WAIT] = sync_mode_q ? rx_len_max_evt : wait_timeout_evt;
        cause[`CSI_CAUSE_CARD] = card_event_evt || tmr_fail || fault_rise;
        cause[`CSI_CAUSE_TMR] = tmr_expired;
    end

    // flags set regardless of enables; set beats clear
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            status_q <= 8'h00;
        end else begin
            status_q <= (status_q & ~(wr_status ? wr_data : 8'h00)) | cause;
        end
    end

    // one request from any enabled flag
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            irq <= 1'b0;
        end else begin
            irq <= |(status_q & irq_en_q);
        end
    end

    // power down follows control bit 0
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            circuit_power_down <= 1'b0;
        end else begin
            circuit_power_down <= pd_q;
        end
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rd_data <= 8'h00;
        end else if (!rd_en) begin
            rd_data <= 8'h00;
        end else begin
            unique case (addr)
                `CSI_ADDR_STATUS: begin
                    rd_data <= status_q;
                end
                `CSI_ADDR_IRQ_EN: begin
                    rd_data <= irq_en_q;
                end
                `CSI_ADDR_CTRL: begin
                    rd_data <= {sel_q, policy_q, rdy_q, good_s_q, 2'h0, pd_q};
                end
                `CSI_ADDR_TIMER: begin
                    rd_data <= timer_q;
                end
                `CSI_ADDR_MODE: begin
                    rd_data <= {7'h00, sync_mode_q};
                end
                default: begin
                    rd_data <= 8'h00; // Unmapped reads zero
                end
            endcase
        end
    end

endmodule : csi_top

// ==== rtl/csi_consts.svh ====
// Offsets, field positions, reset values and timing counts of the card supply and interrupt block
// Function
// - Interrupt enable register holds one enable per cause, bit 7 down to 0.
// - In synchronous mode enable bit 7 gates the receive-length maximum interrupt.
// - Cleared enable only blocks the request; the cause flag still sets.
// - Writing non-zero supply select starts card activation toward that supply.
// - Supply select decodes 00 off, 01 1.8V, 10 3.0V, 11 5V.
// - Card event or supply good falling starts deactivation automatically.
// - Deactivation steps reset, clock, I/O first, then turns supply off.
// - Policy bit 0 and core fault drive both companion commands high at once.
// - Ready-start set: activation continues only once supply good is 1.
// - Ready-start clear: deactivation begins when supply stable timer expires without supply good.
// - Supply good status bit 3 is read-only, shows card supply stable.
// - Control bit 0 selects circuit power down: 1 down, 0 normal.
// - Supply good checked after timer value times 30.5 us; zero means none.
`ifndef CSI_CONSTS_SVH
`define CSI_CONSTS_SVH

// Register byte addresses
`define CSI_ADDR_STATUS 16'hFE01
`define CSI_ADDR_IRQ_EN 16'hFE02
`define CSI_ADDR_CTRL 16'hFE03
`define CSI_ADDR_TIMER 16'hFE04
`define CSI_ADDR_MODE 16'hFE08

// Reset values
`define CSI_RST_IRQ_EN 8'h00
`define CSI_RST_CTRL 8'h00
`define CSI_RST_TIMER 8'h0F
`define CSI_RST_MODE 8'h00

// Control register fields
`define CSI_SEL_HI 7
`define CSI_SEL_LO 6
`define CSI_POLICY_BIT 5
`define CSI_RDY_BIT 4
`define CSI_GOOD_BIT 3
`define CSI_PD_BIT 0

// Cause bit positions
`define CSI_CAUSE_WAIT 7
`define CSI_CAUSE_CARD 6
`define CSI_CAUSE_TMR 5

// Timing
`define CSI_CLK_NS 100
`define CSI_TICK_NS 30500
`define CSI_TICK_CYCLES ((`CSI_TICK_NS + `CSI_CLK_NS - 1) / `CSI_CLK_NS)
`define CSI_STEP_NS 1000
`define CSI_STEP_CYCLES ((`CSI_STEP_NS + `CSI_CLK_NS - 1) / `CSI_CLK_NS)

`endif

// ==== rtl/csi_pkg.sv ====
// Types shared by the card supply and interrupt block
package csi_pkg;

    // Supply sequencer states
    typedef enum logic [3:0] {
        CSI_IDLE = 4'h0,
        CSI_RAMP = 4'h1,
        CSI_ACT_IO = 4'h2,
        CSI_ACT_CLK = 4'h3,
        CSI_ACTIVE = 4'h4,
        CSI_DEA_RST = 4'h5,
        CSI_DEA_CLK = 4'h6,
        CSI_DEA_IO = 4'h7,
        CSI_DEA_OFF = 4'h8,
        CSI_LOCK = 4'h9
    } csi_state_t;

    // Supply select codes
    typedef enum logic [1:0] {
        CSI_VCC_OFF = 2'h0,
        CSI_VCC_1V8 = 2'h1,
        CSI_VCC_3V0 = 2'h2,
        CSI_VCC_5V0 = 2'h3
    } csi_vsel_t;

endpackage : csi_pkg

// ==== rtl/csi_timer.sv ====
// Supply stable timer: counts 30.5 us ticks up to a 4-bit limit
`include "csi_consts.svh"

module csi_timer #(
    parameter int TICK_CYCLES = `CSI_TICK_CYCLES
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic arm,
    input wire logic [3:0] limit,
    output logic expired
);

    logic [15:0] div_q;
    logic [3:0] cnt_q;
    logic done_q;
    logic tick;

    assign tick = (div_q == 16'(TICK_CYCLES - 1));

    // Tick divider, only runs while armed so each check starts fresh
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            div_q <= 16'h0000;
        end else if (!arm || tick) begin
            div_q <= 16'h0000;
        end else begin
            div_q <= div_q + 16'h0001;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_q <= 4'h0;
            done_q <= 1'b0;
            expired <= 1'b0;
        end else if (!arm) begin
            cnt_q <= 4'h0;
            done_q <= 1'b0;
            expired <= 1'b0;
        end else begin
            expired <= 1'b0;
            if (tick && !done_q && limit != 4'h0) begin
                cnt_q <= cnt_q + 4'h1;
                if (cnt_q + 4'h1 == limit) begin
                    done_q <= 1'b1; // One pulse per arming
                    expired <= 1'b1;
                end
            end
        end
    end

endmodule : csi_timer

// ==== verification/csi_assertions.sv ====
// Port checker for the card supply and interrupt block
module csi_assertions (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [15:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic wr_en,
    input wire logic card_event_evt,
    input wire logic core_fault_pin,
    input wire logic irq,
    input wire logic companion_cmd_low_volt_n,
    input wire logic companion_cmd_high_volt_n,
    input wire logic [1:0] supply_level,
    input wire logic card_rst_n,
    input wire logic card_clk_en,
    input wire logic card_io_en,
    input wire logic circuit_power_down
);
    logic [7:0] en_q;
    logic pol_q;
    logic arm_q;
    logic [1:0] sel_q;
    // Shadow of firmware writes, since enables and policy are not ports
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            en_q <= 8'h00;
            pol_q <= 1'b0;
            arm_q <= 1'b1;
            sel_q <= 2'h0;
        end else if (wr_en && addr == 16'hFE02) begin
            en_q <= wr_data;
        end else if (wr_en && addr == 16'hFE03) begin
            pol_q <= wr_data[5];
            arm_q <= wr_data[7:6] == 2'h0;
            sel_q <= wr_data[7:6];
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    sequence s_ctrl_wr;
        wr_en && addr == 16'hFE03;
    endsequence
    sequence s_start;
        s_ctrl_wr ##0 (wr_data[7:6] != 2'h0 && arm_q && supply_level == 2'h0);
    endsequence
    AST_IRQ_SET: assert property (card_event_evt && en_q[6] |-> ##[1:3] irq)
        else $error("irq missing after enabled event");
    AST_IRQ_MASK: assert property (wr_en && addr == 16'hFE02 && wr_data == 8'h00 |-> ##2 !irq)
        else $error("irq stays high with all enables clear");
    AST_PD_FOLLOW: assert property (s_ctrl_wr |-> ##2 circuit_power_down == $past(wr_data[0], 2))
        else $error("power down does not follow control bit 0");
    AST_START: assert property (s_start |-> ##[1:2] (supply_level == sel_q &&
        companion_cmd_high_volt_n == (sel_q != 2'h3) && companion_cmd_low_volt_n == (sel_q == 2'h3)))
        else $error("activation did not command selected supply");
    AST_FAULT_CMD: assert property (!pol_q && $rose(core_fault_pin) |-> ##[1:5]
        (companion_cmd_low_volt_n && companion_cmd_high_volt_n))
        else $error("core fault did not raise both commands");
    AST_EVT_DEACT: assert property (card_event_evt && card_rst_n |-> ##[1:2] !card_rst_n)
        else $error("card event did not start deactivation");
    AST_RST_FIRST: assert property ($fell(card_rst_n) |-> card_clk_en && card_io_en)
        else $error("card reset not first in deactivation");
    AST_IO_LAST: assert property ($fell(card_io_en) |-> !card_clk_en && !card_rst_n)
        else $error("io released before reset and clock");
    AST_ACT_ORDER: assert property ($rose(card_rst_n) |-> card_clk_en && card_io_en && supply_level != 2'h0)
        else $error("card reset released before contacts ready");
endmodule : csi_assertions

bind csi_top csi_assertions u_csi_assertions (.clk, .rst_b, .addr, .wr_data, .wr_en, .card_event_evt,
    .core_fault_pin, .irq, .companion_cmd_low_volt_n, .companion_cmd_high_volt_n, .supply_level,
    .card_rst_n, .card_clk_en, .card_io_en, .circuit_power_down);

// ==== verification/csi_supply_model.sv ====
// Companion supply circuit model: ramps supply good after a command
module csi_supply_model (
    input wire logic clk,
    input wire logic cmd_low_n,
    input wire logic cmd_high_n,
    input wire logic stuck,
    input wire logic [3:0] ramp,
    output logic good
);
    timeunit 1ns;
    timeprecision 1ns;
    int cnt = 0;
    initial good = 1'b0;
    // both high removes supply; stuck models a failed regulator
    always @(posedge clk) begin
        if ((cmd_low_n && cmd_high_n) || stuck) begin
            cnt <= 0;
            good <= 1'b0;
        end else begin
            cnt <= (cnt < 15) ? cnt + 1 : cnt;
            good <= cnt >= ramp;
        end
    end
endmodule : csi_supply_model

// ==== verification/card_supply_irq_control_tb.sv ====
// Self-checking bench for the card supply and interrupt block
module card_supply_irq_control_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [15:0] addr = 16'h0000;
    logic [7:0] wr_data = 8'h00;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic [7:0] ev = 8'h00;
    logic rx_len = 1'b0;
    logic fault = 1'b0;
    logic stuck = 1'b0;
    logic good;
    logic [7:0] rd_data;
    logic irq, cmd_lo_n, cmd_hi_n, rst_n, cken, ioen, pd;
    logic [1:0] lvl;
    logic [7:0] v, r;
    int n_errors = 0;
    int comparisons = 0;
    int cycles = 0;
    int seed = 61;
    int exp_st;

    csi_top #(.STEP_CYCLES(2), .TICK_CYCLES(3)) u_csi_top (.clk(clk), .rst_b(rst_b), .addr(addr),
        .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .wait_timeout_evt(ev[7]),
        .rx_len_max_evt(rx_len), .card_event_evt(ev[6]), .rx_avail_evt(ev[4]), .tx_event_evt(ev[3]),
        .tx_sent_evt(ev[2]), .tx_error_evt(ev[1]), .rx_error_evt(ev[0]), .supply_good_pin(good),
        .core_fault_pin(fault), .irq(irq), .companion_cmd_low_volt_n(cmd_lo_n),
        .companion_cmd_high_volt_n(cmd_hi_n), .supply_level(lvl), .card_rst_n(rst_n),
        .card_clk_en(cken), .card_io_en(ioen), .circuit_power_down(pd));
    csi_supply_model u_csi_supply_model (.clk(clk), .cmd_low_n(cmd_lo_n), .cmd_high_n(cmd_hi_n),
        .stuck(stuck), .ramp(4'h4), .good(good));

    // Clock and hang guard
    initial forever #50 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            close_out();
        end
    end

    function automatic logic [7:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction : xs
    task automatic close_out();
        if (n_errors == 0 && comparisons > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : close_out
    task automatic check(input logic [7:0] seen, input logic [7:0] expv);
        comparisons++;
        if (seen !== expv) begin
            n_errors++;
            $display("ERROR %0t seen %h expected %h", $time, seen, expv);
        end
    endtask : check
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask : wr
    // Read data lands in the cycle after the strobe only
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1 d = rd_data;
    endtask : rd
    task automatic pulse(input int i);
        @(posedge clk);
        if (i == 8) rx_len <= 1'b1;
        else ev[i] <= 1'b1;
        @(posedge clk);
        ev <= 8'h00;
        rx_len <= 1'b0;
    endtask : pulse
    task automatic wait_for(input logic want);
        int k;
        k = 0;
        while (rst_n !== want && k < 200) begin
            @(posedge clk);
            k++;
        end
        check(8'(rst_n), 8'(want));
    endtask : wait_for
    // Long enough for a full four-step deactivation
    task automatic settle();
        repeat (24) @(posedge clk);
    endtask : settle
    task automatic act(input logic [1:0] s, input logic [5:0] low);
        wr(16'hFE03, {s, low});
        wait_for(1'b1);
        check(8'(lvl), 8'(s));
        check(8'({cken, ioen}), 8'h03);
        check(8'({cmd_hi_n, cmd_lo_n}), (s == 2'h3) ? 8'h01 : 8'h02);
    endtask : act

    initial begin
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        // reset values, unmapped read, random enables
        rd(16'hFE03, r);
        check(r, 8'h00);
        rd(16'hFE10, r);
        check(r, 8'h00);
        v = xs();
        wr(16'hFE02, v);
        rd(16'hFE02, r);
        check(r, v);
        // supply good is read-only, power down bit
        wr(16'hFE03, 8'h09);
        rd(16'hFE03, r);
        check(r, 8'h01);
        check(8'(pd), 8'h01);
        wr(16'hFE03, 8'h00);
        wr(16'hFE01, 8'hFF);
        for (int i = 0; i < 9; i++) begin
            if (i == 5) continue;
            wr(16'hFE08, (i == 8) ? 8'h01 : 8'h00);
            wr(16'hFE02, 8'h00);
            pulse(i);
            exp_st = 1 << ((i == 8) ? 7 : i);
            rd(16'hFE01, r);
            check(r, 8'(exp_st));
            check(8'(irq), 8'h00);
            wr(16'hFE02, 8'(exp_st));
            @(posedge clk);
            #1 check(8'(irq), 8'h01);
            wr(16'hFE01, 8'(exp_st));
            @(posedge clk);
            #1 check(8'(irq), 8'h00);
        end
        wr(16'hFE08, 8'h00);
        wr(16'hFE04, 8'h05);
        // every supply level with ready start
        for (int s = 1; s < 4; s++) begin
            act(2'(s), 6'h10);
            rd(16'hFE03, r);
            check(r, {2'(s), 6'h18});
            wr(16'hFE03, 8'h00);
            settle();
        end
        // card event stop, then locked select
        wr(16'hFE02, 8'h40);
        act(2'h2, 6'h10);
        pulse(6);
        wait_for(1'b0);
        settle();
        check(8'({lvl, cmd_hi_n, cmd_lo_n, cken, ioen}), 8'h0C);
        check(8'(irq), 8'h01);
        wr(16'hFE03, 8'h90);
        settle();
        check(8'(lvl), 8'h00);
        wr(16'hFE03, 8'h00);
        settle();
        act(2'h1, 6'h10);
        stuck <= 1'b1;
        wait_for(1'b0);
        settle();
        wr(16'hFE03, 8'h00);
        wr(16'hFE01, 8'hFF);
        wr(16'hFE03, 8'h40);
        repeat (30) @(posedge clk);
        rd(16'hFE01, r);
        check(r & 8'h40, 8'h40);
        check(8'({lvl, rst_n}), 8'h00);
        wr(16'hFE03, 8'h00);
        settle();
        // zero timer waits for supply good
        wr(16'hFE04, 8'h00);
        wr(16'hFE03, 8'h40);
        repeat (40) @(posedge clk);
        check(8'({lvl, rst_n}), 8'h02);
        stuck <= 1'b0;
        wait_for(1'b1);
        wr(16'hFE03, 8'h00);
        settle();
        act(2'h3, 6'h10);
        fault <= 1'b1;
        repeat (5) @(posedge clk);
        check(8'({cmd_hi_n, cmd_lo_n}), 8'h03);
        fault <= 1'b0;
        wr(16'hFE03, 8'h00);
        settle();
        // fault with policy set, firmware removes supply
        act(2'h3, 6'h30);
        fault <= 1'b1;
        repeat (8) @(posedge clk);
        check(8'({rst_n, cmd_hi_n}), 8'h02);
        fault <= 1'b0;
        wr(16'hFE03, 8'h20);
        settle();
        check(8'({lvl, cmd_hi_n, cmd_lo_n}), 8'h03);
        close_out();
    end
endmodule : card_supply_irq_control_tb
